// file: hw/bsta_tap.sv
// boundary scan access port, one or two dies chained on one set of pins
// Function
// - five tms-high tck edges force reset
// - port reset leaves memory logic running
// - data shift-pause-shift repeats pending bit once
// - four-bit instr, one-bit bypass, 32-bit id
// - extest captures ring, boundary on path
// - bypass instruction selects one-bit bypass
// - idcode loads identification, selects it
// - highz selects bypass, floats all outputs
// - clamp drives pins from boundary, bypass
// - sample captures ring, pins undisturbed
// - code 1100 resets non-scan logic
// - id version, part, vendor field layout
// - id bit zero is constant one
// - two dies chained, shared tms tck
// - each die has own instruction register
// - three inputs and one serial output
`default_nettype none
module bsta_tap #(
  parameter int NUM_DIES = 1 // two for the chained two-die part
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [NUM_DIES-1:0][bsta_pkg::BSTA_BND_LEN-1:0] ring_in,
  output logic [NUM_DIES-1:0][bsta_pkg::BSTA_BND_LEN-1:0] ring_out,
  output logic [NUM_DIES-1:0] ring_drive,
  output logic [NUM_DIES-1:0] pins_highz,
  output logic [NUM_DIES-1:0] nonscan_logic_reset_instr
);
  localparam int IW = bsta_pkg::BSTA_IR_W;
  localparam int DW = bsta_pkg::BSTA_ID_W;

  bsta_pkg::bsta_pins_t pins_raw; // pins as one group
  bsta_pkg::bsta_pins_t pins_s; // pins after synchroniser
  logic tck_prev_q; // last synced tck, for edge detection
  logic rise; // tck rising edge seen this cycle
  logic fall; // tck falling edge seen this cycle

  assign pins_raw = '{tck: tck, tms: tms, tdi: tdi};

  // every pin passes two flops before use
  bsta_sync u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pins_in(pins_raw),
    .pins_out(pins_s)
  );

  // edge finder on the synced clock
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      tck_prev_q <= 1'h0;
    else
      tck_prev_q <= pins_s.tck;
  end
  assign rise = pins_s.tck & ~tck_prev_q;
  assign fall = ~pins_s.tck & tck_prev_q;

  // per-die scan state
  bsta_pkg::bsta_state_t st_q [NUM_DIES];
  bsta_pkg::bsta_state_t st_d [NUM_DIES];
  logic [IW-1:0] irs_q [NUM_DIES]; // instruction shifter
  logic [IW-1:0] irs_d [NUM_DIES];
  logic [IW-1:0] ir_q [NUM_DIES]; // active instruction
  logic [IW-1:0] ir_d [NUM_DIES];
  logic [DW-1:0] ids_q [NUM_DIES]; // identification shifter
  logic [DW-1:0] ids_d [NUM_DIES];
  logic byp_q [NUM_DIES]; // bypass bit
  logic byp_d [NUM_DIES];
  logic rep_q [NUM_DIES]; // pending bit must be repeated
  logic rep_d [NUM_DIES];
  logic dto_q [NUM_DIES]; // die serial out, falling-edge updated
  logic dto_d [NUM_DIES];
  logic doe_q [NUM_DIES]; // die is shifting
  logic doe_d [NUM_DIES];
  logic din [NUM_DIES]; // die serial in
  logic bso [NUM_DIES]; // boundary ring serial out
  bsta_pkg::bsta_bctl_t bctl [NUM_DIES]; // boundary strobes
  logic [NUM_DIES-1:0] drv_q, drv_d; // pins from boundary latch
  logic [NUM_DIES-1:0] hz_q, hz_d; // all outputs floated
  logic [NUM_DIES-1:0] nsr_q, nsr_d; // non-scan logic held in reset
  logic [2:0] tms_cnt_q, tms_cnt_d; // consecutive tms-high rising edges

  genvar g;
  generate
    for (g = 0; g < NUM_DIES; g++)
    begin : g_die
      bsta_pkg::bsta_sel_t sel; // data register in the path
      logic dr_shift; // a data shift happens on this edge
      logic odr; // selected data register output
      assign sel = bsta_pkg::bsta_sel_of(ir_q[g]);

      // first die takes the pin, later dies the previous die's output
      if (g == 0)
      begin : g_first
        assign din[g] = pins_s.tdi;
      end
      else
      begin : g_chain
        assign din[g] = dto_q[g-1];
      end

      // a return from pause skips one shift so the pending bit shows twice
      assign dr_shift = rise && st_q[g] == bsta_pkg::BSTA_SH_DR && !rep_q[g];

      assign bctl[g] = '{
        capture: rise && st_q[g] == bsta_pkg::BSTA_CAP_DR && sel == bsta_pkg::BSTA_SEL_BND,
        shift: dr_shift && sel == bsta_pkg::BSTA_SEL_BND,
        update: rise && st_q[g] == bsta_pkg::BSTA_UPD_DR && sel == bsta_pkg::BSTA_SEL_BND
      };

      bsta_bring u_ring (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ctl(bctl[g]),
        .scan_in(din[g]),
        .ring_in(ring_in[g]),
        .scan_out(bso[g]),
        .ring_out(ring_out[g])
      );

      always_comb
      begin
        unique case (sel)
          bsta_pkg::BSTA_SEL_ID: odr = ids_q[g][0];
          bsta_pkg::BSTA_SEL_BND: odr = bso[g];
          default: odr = byp_q[g];
        endcase
      end

      // next values of controller, instruction and data shifters
      always_comb
      begin
        st_d[g] = st_q[g];
        irs_d[g] = irs_q[g];
        ir_d[g] = ir_q[g];
        ids_d[g] = ids_q[g];
        byp_d[g] = byp_q[g];
        rep_d[g] = rep_q[g];
        dto_d[g] = dto_q[g];
        doe_d[g] = doe_q[g];
        if (rise)
        begin
          st_d[g] = bsta_pkg::bsta_next(st_q[g], pins_s.tms);
          unique case (st_q[g])
            bsta_pkg::BSTA_RESET:
              ir_d[g] = bsta_pkg::BSTA_I_IDCODE; // port reset only touches scan logic
            bsta_pkg::BSTA_CAP_IR:
              irs_d[g] = bsta_pkg::BSTA_IR_CAPTURE;
            bsta_pkg::BSTA_SH_IR:
              irs_d[g] = {din[g], irs_q[g][IW-1:1]}; // own register per die
            bsta_pkg::BSTA_UPD_IR:
              ir_d[g] = irs_q[g];
            bsta_pkg::BSTA_CAP_DR:
            begin
              byp_d[g] = 1'h0;
              if (sel == bsta_pkg::BSTA_SEL_ID)
                ids_d[g] = bsta_pkg::BSTA_ID_VALUE;
            end
            bsta_pkg::BSTA_SH_DR:
            begin
              if (rep_q[g])
                rep_d[g] = 1'h0; // duplicate spent
              else if (sel == bsta_pkg::BSTA_SEL_ID)
                ids_d[g] = {din[g], ids_q[g][DW-1:1]};
              else if (sel == bsta_pkg::BSTA_SEL_BYP)
                byp_d[g] = din[g];
            end
            bsta_pkg::BSTA_EX2_DR:
              rep_d[g] = !pins_s.tms; // back to shift from pause
            default:
              rep_d[g] = rep_q[g];
          endcase
          // entering reset restores the default instruction at once, so no
          // mode such as the non-scan reset outlives the port reset
          if (st_d[g] == bsta_pkg::BSTA_RESET)
            ir_d[g] = bsta_pkg::BSTA_I_IDCODE;
        end
        // serial output moves only on the falling edge
        if (fall)
        begin
          doe_d[g] = st_q[g] == bsta_pkg::BSTA_SH_DR || st_q[g] == bsta_pkg::BSTA_SH_IR;
          if (st_q[g] == bsta_pkg::BSTA_SH_IR)
            dto_d[g] = irs_q[g][0];
          else if (st_q[g] == bsta_pkg::BSTA_SH_DR)
            dto_d[g] = odr;
        end
        // pin modes follow the active instruction
        drv_d[g] = ir_q[g] == bsta_pkg::BSTA_I_EXTEST
                   || ir_q[g] == bsta_pkg::BSTA_I_CLAMP;
        hz_d[g] = ir_q[g] == bsta_pkg::BSTA_I_HIGHZ;
        nsr_d[g] = ir_q[g] == bsta_pkg::BSTA_I_NONSCAN_RST;
      end

      // register one die's state
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          st_q[g] <= bsta_pkg::BSTA_RESET;
          irs_q[g] <= '0;
          ir_q[g] <= bsta_pkg::BSTA_I_IDCODE;
          ids_q[g] <= '0;
          byp_q[g] <= 1'h0;
          rep_q[g] <= 1'h0;
          dto_q[g] <= 1'h0;
          doe_q[g] <= 1'h0;
          drv_q[g] <= 1'h0;
          hz_q[g] <= 1'h0;
          nsr_q[g] <= 1'h0;
        end
        else
        begin
          st_q[g] <= st_d[g];
          irs_q[g] <= irs_d[g];
          ir_q[g] <= ir_d[g];
          ids_q[g] <= ids_d[g];
          byp_q[g] <= byp_d[g];
          rep_q[g] <= rep_d[g];
          dto_q[g] <= dto_d[g];
          doe_q[g] <= doe_d[g];
          drv_q[g] <= drv_d[g];
          hz_q[g] <= hz_d[g];
          nsr_q[g] <= nsr_d[g];
        end
      end
    end
  endgenerate

  // helper count of consecutive tms-high rising edges, only assertions and covers read it
  always_comb
  begin
    tms_cnt_d = tms_cnt_q;
    if (rise)
      tms_cnt_d = !pins_s.tms ? 3'h0 :
                  tms_cnt_q == bsta_pkg::BSTA_TMS_CNT_MAX ? tms_cnt_q : tms_cnt_q + 3'h1;
  end
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      tms_cnt_q <= 3'h0;
    else
      tms_cnt_q <= tms_cnt_d;
  end

  // outputs straight from flops; the last die drives the package pin
  assign tdo = dto_q[NUM_DIES-1];
  assign tdo_oe = doe_q[NUM_DIES-1];
  assign ring_drive = drv_q;
  assign pins_highz = hz_q;
  assign nonscan_logic_reset_instr = nsr_q;

  // checks on die 0
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  tms_reset_a: assert property (tms_cnt_q >= bsta_pkg::BSTA_TMS_RESET_EDGES
    |-> st_q[0] == bsta_pkg::BSTA_RESET) else $error("no reset after five tms-high edges");
  reset_keep_a: assert property (st_q[0] == bsta_pkg::BSTA_RESET
    |=> ##1 !nsr_q[0]) else $error("port reset disturbed memory logic");
  pause_dup_a: assert property (rise && st_q[0] == bsta_pkg::BSTA_EX2_DR && !pins_s.tms
    |=> rep_q[0] && st_q[0] == bsta_pkg::BSTA_SH_DR) else $error("no repeat after pause");
  ir_cap_a: assert property (rise && st_q[0] == bsta_pkg::BSTA_CAP_IR
    |=> irs_q[0] == bsta_pkg::BSTA_IR_CAPTURE) else $error("bad instruction capture");
  byp_out_a: assert property (fall && st_q[0] == bsta_pkg::BSTA_SH_DR
    && ir_q[0] == bsta_pkg::BSTA_I_BYPASS |=> dto_q[0] == $past(byp_q[0]))
    else $error("bypass bit not on output");
  id_load_a: assert property (rise && st_q[0] == bsta_pkg::BSTA_CAP_DR
    && ir_q[0] == bsta_pkg::BSTA_I_IDCODE |=> ids_q[0] == bsta_pkg::BSTA_ID_VALUE
    && ids_q[0][0]) else $error("identification not loaded");
  highz_mode_a: assert property (ir_q[0] == bsta_pkg::BSTA_I_HIGHZ
    |=> hz_q[0] && !drv_q[0]) else $error("highz mode wrong");
  clamp_mode_a: assert property (ir_q[0] == bsta_pkg::BSTA_I_CLAMP
    |=> drv_q[0] && !hz_q[0]) else $error("clamp mode wrong");
  sample_mode_a: assert property (ir_q[0] == bsta_pkg::BSTA_I_SAMPLE
    |=> !drv_q[0] && !hz_q[0]) else $error("sample disturbed pins");
  nonscan_rst_a: assert property (ir_q[0] == bsta_pkg::BSTA_I_NONSCAN_RST
    |=> nsr_q[0]) else $error("non-scan reset missing");
  oe_shift_a: assert property (fall && st_q[0] == bsta_pkg::BSTA_SH_DR
    |=> doe_q[0]) else $error("serial output not enabled in shift");
  rsvd_byp_a: assert property (ir_q[0] != bsta_pkg::BSTA_I_EXTEST
    && ir_q[0] != bsta_pkg::BSTA_I_SAMPLE && ir_q[0] != bsta_pkg::BSTA_I_IDCODE
    |-> g_die[0].sel == bsta_pkg::BSTA_SEL_BYP) else $error("bypass not selected");
  port_rst_a: assert property (rise && st_q[0] == bsta_pkg::BSTA_SEL_IR
    && pins_s.tms |=> ir_q[0] == bsta_pkg::BSTA_I_IDCODE) else $error("instruction not reset");

  id_read_c: cover property (rise && st_q[0] == bsta_pkg::BSTA_CAP_DR
    && ir_q[0] == bsta_pkg::BSTA_I_IDCODE);
  pause_back_c: cover property (rise && rep_q[0] && st_q[0] == bsta_pkg::BSTA_SH_DR);
  ir_update_c: cover property (rise && st_q[0] == bsta_pkg::BSTA_UPD_IR);
  tap_reset_c: cover property (tms_cnt_q == bsta_pkg::BSTA_TMS_RESET_EDGES);
endmodule : bsta_tap
`default_nettype wire

// file: hw/bsta_pkg.sv
// shared constants, types and decode functions of the boundary scan access port
`default_nettype none
package bsta_pkg;
  // scan register sizes
  localparam int BSTA_IR_W = 4;
  localparam int BSTA_ID_W = 32;
  localparam int BSTA_BND_LEN = 8; // boundary ring length, plain default per device
  // tck rising edges with tms high that force the controller into reset
  localparam logic [2:0] BSTA_TMS_RESET_EDGES = 3'h5;
  localparam logic [2:0] BSTA_TMS_CNT_MAX = 3'h7;
  // instruction codes
  localparam logic [3:0] BSTA_I_EXTEST = 4'h0;
  localparam logic [3:0] BSTA_I_BYPASS = 4'hF;
  localparam logic [3:0] BSTA_I_IDCODE = 4'hB;
  localparam logic [3:0] BSTA_I_HIGHZ = 4'h7;
  localparam logic [3:0] BSTA_I_CLAMP = 4'h4;
  localparam logic [3:0] BSTA_I_SAMPLE = 4'h8;
  localparam logic [3:0] BSTA_I_NONSCAN_RST = 4'hC;
  // fixed pattern captured into the instruction shifter
  localparam logic [3:0] BSTA_IR_CAPTURE = 4'h1;
  // identification fields; all three values are arbitrary
  localparam logic [3:0] BSTA_ID_VERSION = 4'h1;
  localparam logic [15:0] BSTA_ID_PART = 16'h5A5A;
  localparam logic [10:0] BSTA_ID_VENDOR = 11'h2A5;
  localparam logic BSTA_ID_PRESENT = 1'h1;
  localparam logic [31:0] BSTA_ID_VALUE =
    {BSTA_ID_VERSION, BSTA_ID_PART, BSTA_ID_VENDOR, BSTA_ID_PRESENT};
  // the sixteen controller states
  typedef enum logic [3:0] {
    BSTA_RESET = 4'h0, BSTA_IDLE = 4'h1, BSTA_SEL_DR = 4'h2, BSTA_CAP_DR = 4'h3,
    BSTA_SH_DR = 4'h4, BSTA_EX1_DR = 4'h5, BSTA_PA_DR = 4'h6, BSTA_EX2_DR = 4'h7,
    BSTA_UPD_DR = 4'h8, BSTA_SEL_IR = 4'h9, BSTA_CAP_IR = 4'hA, BSTA_SH_IR = 4'hB,
    BSTA_EX1_IR = 4'hC, BSTA_PA_IR = 4'hD, BSTA_EX2_IR = 4'hE, BSTA_UPD_IR = 4'hF
  } bsta_state_t;
  // data register chosen by the current instruction
  typedef enum logic [1:0] {
    BSTA_SEL_BYP = 2'h0,
    BSTA_SEL_ID = 2'h1,
    BSTA_SEL_BND = 2'h2
  } bsta_sel_t;
  // test pins as one group
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bsta_pins_t;
  // boundary ring strobes, each valid for one clk_sys cycle
  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
  } bsta_bctl_t;

  // controller step on a tck rising edge
  function automatic bsta_state_t bsta_next(input bsta_state_t s, input logic tms);
    unique case (s)
      BSTA_RESET: bsta_next = tms ? BSTA_RESET : BSTA_IDLE;
      BSTA_IDLE: bsta_next = tms ? BSTA_SEL_DR : BSTA_IDLE;
      BSTA_SEL_DR: bsta_next = tms ? BSTA_SEL_IR : BSTA_CAP_DR;
      BSTA_CAP_DR: bsta_next = tms ? BSTA_EX1_DR : BSTA_SH_DR;
      BSTA_SH_DR: bsta_next = tms ? BSTA_EX1_DR : BSTA_SH_DR;
      BSTA_EX1_DR: bsta_next = tms ? BSTA_UPD_DR : BSTA_PA_DR;
      BSTA_PA_DR: bsta_next = tms ? BSTA_EX2_DR : BSTA_PA_DR;
      BSTA_EX2_DR: bsta_next = tms ? BSTA_UPD_DR : BSTA_SH_DR;
      BSTA_UPD_DR: bsta_next = tms ? BSTA_SEL_DR : BSTA_IDLE;
      BSTA_SEL_IR: bsta_next = tms ? BSTA_RESET : BSTA_CAP_IR;
      BSTA_CAP_IR: bsta_next = tms ? BSTA_EX1_IR : BSTA_SH_IR;
      BSTA_SH_IR: bsta_next = tms ? BSTA_EX1_IR : BSTA_SH_IR;
      BSTA_EX1_IR: bsta_next = tms ? BSTA_UPD_IR : BSTA_PA_IR;
      BSTA_PA_IR: bsta_next = tms ? BSTA_EX2_IR : BSTA_PA_IR;
      BSTA_EX2_IR: bsta_next = tms ? BSTA_UPD_IR : BSTA_SH_IR;
      BSTA_UPD_IR: bsta_next = tms ? BSTA_SEL_DR : BSTA_IDLE;
    endcase
  endfunction : bsta_next

  // instruction to data register; reserved codes fall back to bypass
  function automatic bsta_sel_t bsta_sel_of(input logic [3:0] ir);
    unique case (ir)
      BSTA_I_EXTEST, BSTA_I_SAMPLE: bsta_sel_of = BSTA_SEL_BND;
      BSTA_I_IDCODE: bsta_sel_of = BSTA_SEL_ID;
      default: bsta_sel_of = BSTA_SEL_BYP;
    endcase
  endfunction : bsta_sel_of
endpackage : bsta_pkg
`default_nettype wire

// file: hw/bsta_sync.sv
// two-flop synchroniser for the asynchronous test pins
`default_nettype none
module bsta_sync (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire bsta_pkg::bsta_pins_t pins_in,
  output bsta_pkg::bsta_pins_t pins_out
);
  bsta_pkg::bsta_pins_t meta_q; // first stage, read only by the second
  bsta_pkg::bsta_pins_t sync_q; // second stage

  // both stages clear to a constant under reset
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= pins_in;
      sync_q <= meta_q;
    end
  end

  assign pins_out = sync_q;
endmodule : bsta_sync
`default_nettype wire

// file: hw/bsta_bring.sv
// boundary ring: capture/shift stage plus update latch driving the pins
`default_nettype none
module bsta_bring (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire bsta_pkg::bsta_bctl_t ctl,
  input wire logic scan_in,
  input wire logic [bsta_pkg::BSTA_BND_LEN-1:0] ring_in,
  output logic scan_out,
  output logic [bsta_pkg::BSTA_BND_LEN-1:0] ring_out
);
  localparam int L = bsta_pkg::BSTA_BND_LEN;
  logic [L-1:0] sr_q, sr_d; // shift stage
  logic [L-1:0] up_q, up_d; // update stage, holds what the pins see

  // capture has priority, strobes are mutually exclusive anyway
  always_comb
  begin
    sr_d = sr_q;
    up_d = up_q;
    if (ctl.capture)
      sr_d = ring_in;
    else if (ctl.shift)
      sr_d = {scan_in, sr_q[L-1:1]};
    if (ctl.update)
      up_d = sr_q;
  end

  // register the ring
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sr_q <= '0;
      up_q <= '0;
    end
    else
    begin
      sr_q <= sr_d;
      up_q <= up_d;
    end
  end

  assign scan_out = sr_q[0];
  assign ring_out = up_q;
endmodule : bsta_bring
`default_nettype wire

// file: verification/bsta_tester.sv
// behavioural test controller that drives the scan pins of the access port
`default_nettype none
module bsta_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  realtime half = 62.5; // half of the 125 ns test clock
  realtime gap = 0.0; // extra low time, lets a scenario answer slowly
  logic oe_q; // output enable seen at the last sample
  logic oe_bad; // set when a shift sample found tdo not driven

  initial
  begin
    tck = 1'b0; // test clock stands still outside frames
    tms = 1'b1;
    tdi = 1'b0;
    oe_bad = 1'b0;
  end

  // one test clock period; pins change just after the falling edge
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #(half + gap);
    q = tdo; // settled since the previous fall
    oe_q = tdo_oe;
    tck = 1'b1;
    #(half);
    tck = 1'b0;
  endtask : step

  // five mode-high rises reach reset from any state, then park in idle
  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b0, q);
  endtask : tap_reset

  // one scan from idle back to idle, lsb first; pause_at 0 means no pause
  task automatic scan(input logic ir, input int n, input logic [79:0] din,
    input int pause_at, output logic [79:0] dout);
    logic q;
    dout = '0;
    oe_bad = 1'b0;
    step(1'b1, 1'b0, q); // select data column
    if (ir)
      step(1'b1, 1'b0, q); // on to the instruction column
    step(1'b0, 1'b0, q); // capture
    step(1'b0, 1'b0, q); // into shift
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1 || i + 1 == pause_at, din[i], dout[i]);
      if (oe_q !== 1'b1)
        oe_bad = 1'b1;
      if (i + 1 == pause_at)
      begin
        // pause only on a scenario's demand
        step(1'b0, 1'b0, q);
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
      end
    end
    step(1'b1, 1'b0, q); // update
    step(1'b0, ~din[n - 1], q); // idle; released tdi shows the inverse
  endtask : scan
endmodule : bsta_tester
`default_nettype wire

// file: verification/bsta_tap_tb.sv
// self-checking bench of the two-die boundary scan access port
`default_nettype none
module bsta_tap_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BL = bsta_pkg::BSTA_BND_LEN;
  // identification word built from its fields
  localparam logic [31:0] ID_EXP = {bsta_pkg::BSTA_ID_VERSION, bsta_pkg::BSTA_ID_PART,
    bsta_pkg::BSTA_ID_VENDOR, 1'b1};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1; // master reset after power-up
  logic tck, tms, tdi, tdo, tdo_oe; // scan pins
  logic [1:0][BL-1:0] ring_in = '0; // capture inputs of both dies
  logic [1:0][BL-1:0] ring_out;
  logic [1:0] ring_drive, pins_highz, nonscan_rst; // per die pin modes
  logic [79:0] got; // last scan result
  int mismatches = 0;
  int checked = 0;

  always #4 clk_sys = ~clk_sys;

  bsta_tap #(
    .NUM_DIES(2)
  ) DUT (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo),
    .tdo_oe(tdo_oe),
    .ring_in(ring_in),
    .ring_out(ring_out),
    .ring_drive(ring_drive),
    .pins_highz(pins_highz),
    .nonscan_logic_reset_instr(nonscan_rst)
  );

  bsta_tester tester (
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo),
    .tdo_oe(tdo_oe)
  );

  // counts a compare and reports a miss at once
  task automatic chk(input logic [79:0] g, input logic [79:0] e, input string what);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : chk

  // loads die 0 with c0 and die 1 with c1; capture pattern comes back
  task automatic ir(input logic [3:0] c0, input logic [3:0] c1);
    tester.scan(1'b1, 8, 80'({c0, c1}), 0, got);
    chk(80'(got[7:0]), 80'h11, "instruction capture");
  endtask : ir

  // both dies answer with identification after reset, die 1 first
  task automatic t_idcode();
    tester.scan(1'b0, 64, 80'h0, 0, got);
    chk(80'(got[63:0]), 80'({ID_EXP, ID_EXP}), "id chain");
    chk(80'(got[0]), 80'h1, "id presence bit");
    chk(80'(tester.oe_bad), 80'h0, "tdo enable while shifting");
    repeat (4) @(negedge clk_sys);
    chk(80'(tdo_oe), 80'h0, "tdo enable after shift");
  endtask : t_idcode

  // one die reads identification while the other is bypassed
  task automatic t_mixed();
    ir(bsta_pkg::BSTA_I_IDCODE, bsta_pkg::BSTA_I_BYPASS);
    tester.scan(1'b0, 33, 80'h0, 0, got);
    chk(80'(got[32:0]), 80'({ID_EXP, 1'b0}), "mixed chain");
  endtask : t_mixed

  // extest, clamp, highz, non-scan reset, code 3 and bypass with pin modes; bypass codes give a two-bit chain
  task automatic t_modes();
    logic [3:0] code [6] = '{bsta_pkg::BSTA_I_EXTEST, bsta_pkg::BSTA_I_CLAMP,
      bsta_pkg::BSTA_I_HIGHZ, bsta_pkg::BSTA_I_NONSCAN_RST, 4'h3, bsta_pkg::BSTA_I_BYPASS};
    logic [2:0] mode [6] = '{3'h4, 3'h4, 3'h2, 3'h1, 3'h0, 3'h0};
    for (int i = 0; i < 6; i++)
    begin
      ir(code[i], code[i]);
      @(negedge clk_sys);
      chk(80'({ring_drive, pins_highz, nonscan_rst}), 80'({{2{mode[i][2]}},
        {2{mode[i][1]}}, {2{mode[i][0]}}}), "pin modes");
      if (i > 0)
      begin
        tester.scan(1'b0, 4, 80'hD, 0, got);
        chk(80'(got[3:0]), 80'h4, "bypass chain");
      end
    end
  endtask : t_modes

  // sample then extest: ring captured, shifted through, then latched
  task automatic t_boundary();
    logic [3:0] code [2] = '{bsta_pkg::BSTA_I_SAMPLE, bsta_pkg::BSTA_I_EXTEST};
    logic [15:0] din;
    for (int i = 0; i < 2; i++)
    begin
      ir(code[i], code[i]);
      @(negedge clk_sys);
      ring_in = (i == 0) ? 16'hC35A : 16'h3CA5;
      din = (i == 0) ? 16'h96E1 : 16'h1E69;
      tester.scan(1'b0, 16, 80'(din), 0, got);
      chk(80'(got[15:0]), 80'({ring_in[0], ring_in[1]}), "ring capture");
      @(negedge clk_sys);
      chk(80'(ring_out), 80'({din[7:0], din[15:8]}), "ring update");
      chk(80'(ring_drive), (i == 0) ? 80'h0 : 80'h3, "pins follow ring");
    end
  endtask : t_boundary

  // pause mid-scan with a slow tester: the pending bit comes out twice
  task automatic t_pause();
    logic [63:0] id64;
    logic [64:0] ex;
    id64 = {ID_EXP, ID_EXP};
    ir(bsta_pkg::BSTA_I_IDCODE, bsta_pkg::BSTA_I_IDCODE);
    for (int j = 0; j < 65; j++)
      ex[j] = id64[(j <= 5) ? j : j - 1];
    tester.gap = 100.0;
    tester.scan(1'b0, 65, 80'h0, 5, got);
    tester.gap = 0.0;
    chk(80'(got[64:0]), 80'(ex), "duplicated bit after pause");
  endtask : t_pause

  // port reset from mid instruction shift leaves the ring latch alone
  task automatic t_tap_reset();
    logic q;
    logic [1:0][BL-1:0] held;
    ir(bsta_pkg::BSTA_I_EXTEST, bsta_pkg::BSTA_I_EXTEST);
    held = ring_out;
    tester.step(1'b1, 1'b1, q);
    tester.step(1'b1, 1'b1, q);
    tester.step(1'b0, 1'b1, q);
    tester.step(1'b0, 1'b1, q);
    tester.tap_reset();
    @(negedge clk_sys);
    chk(80'(ring_out), 80'(held), "latch kept over port reset");
    chk(80'({ring_drive, nonscan_rst}), 80'h0, "modes after port reset");
    t_idcode();
  endtask : t_tap_reset

  // prints the verdict and ends the run
  task automatic wrap_up();
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // main sequence
  initial
  begin
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    tester.tap_reset();
    t_idcode();
    t_mixed();
    t_modes();
    t_boundary();
    t_pause();
    t_tap_reset();
    wrap_up();
  end

  // watchdog: a hang counts as a miss
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end
endmodule : bsta_tap_tb
`default_nettype wire
